// file: inc/scd_pkg.sv
// Constants for the stream command dispatcher: packet types, lengths,
// capability bits and the split of the memory-mapped port.
// Assumes a 64-bit internal command stream and one system clock.
package scd_pkg;
  localparam int DW = 64;
  localparam int CNT_W = 30;
  localparam int CAP_W = 64;
  localparam logic [31:0] TYPE_RESET = 32'h0000_0000;
  localparam logic [31:0] TYPE_STATUS = 32'h0000_0001;
  localparam logic [31:0] TYPE_POW = 32'h0000_0100;
  localparam logic [31:0] TYPE_SIG = 32'h0000_0101;
  localparam logic [31:0] RPL_RESET = 32'h8000_0000;
  localparam logic [31:0] RPL_STATUS = 32'h8000_0001;
  localparam logic [31:0] RPL_IGNORE = 32'h8000_0002;
  localparam logic [31:0] RPL_POW = 32'h8000_0100;
  localparam logic [31:0] RPL_SIG = 32'h8000_0101;
  localparam logic [31:0] RPL_IRQ = 32'h8000_0200;
  localparam logic [31:0] HDR_BYTES = 32'd8;
  localparam logic [31:0] IDX_BYTES = 32'd8;
  localparam logic [31:0] POW_BODY_BYTES = 32'd1487;
  localparam logic [31:0] SIG_BODY_BYTES = 32'd160;
  localparam logic [31:0] STATUS_BYTES = 32'd36;
  localparam logic [31:0] MASK_BYTES = 32'd1;
  localparam logic [31:0] DTYPE_BYTES = 32'd4;
  localparam logic [31:0] LEN_POW = HDR_BYTES + IDX_BYTES + POW_BODY_BYTES;
  localparam logic [31:0] LEN_SIG = HDR_BYTES + IDX_BYTES + SIG_BODY_BYTES;
  localparam logic [31:0] LEN_STATUS = HDR_BYTES + STATUS_BYTES;
  localparam logic [31:0] LEN_IGNORE = HDR_BYTES + HDR_BYTES;
  localparam logic [31:0] LEN_RESULT = HDR_BYTES + IDX_BYTES + MASK_BYTES;
  localparam logic [32:0] WORD_ROUND = 33'd7;
  localparam int WORD_SHIFT = 3;
  localparam int UNIT_SHIFT = 2;
  localparam logic [2:0] STATUS_LAST = 3'd5;
  localparam logic [2:0] IGNORE_LAST = 3'd1;
  localparam logic [2:0] RESULT_LAST = 3'd2;
  localparam int CAP_POW_200_9 = 0;
  localparam int CAP_POW_144_5 = 1;
  localparam int CAP_SIG = 2;
  localparam int CAP_COPROC = 3;
  localparam logic [15:0] MM_CTRL_HI = 16'h0fff;
  localparam logic [15:0] MM_COP_LO = 16'h1000;
  localparam logic [15:0] MM_COP_HI = 16'h4fff;
endpackage

// file: design/scd_top.sv
// Stream command dispatcher: parses command packets from the 64-bit
// inbound stream, feeds verify payloads to the engines and sends replies.
// Assumes engines and coprocessor hold valid until they see ready.
`timescale 1ns/1ps
module scd_top
  import scd_pkg::*;
#(
  parameter logic [31:0] VERSION = 32'h0001_0000,
  parameter logic [63:0] BUILD_DATE = 64'h0,
  parameter logic [63:0] BUILD_HOST = 64'h0,
  parameter logic [CAP_W-1:0] CAP_MASK = 64'hd
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [DW-1:0] rx_tdata,
  input wire logic rx_tvalid,
  output logic rx_tready,
  output logic [DW-1:0] tx_tdata,
  output logic tx_tvalid,
  input wire logic tx_tready,
  output logic tx_tlast,
  output logic [DW-1:0] eng_tdata,
  output logic eng_tvalid,
  input wire logic eng_tready,
  output logic eng_tlast,
  output logic eng_sel_sig,
  output logic eng_soft_rst,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic res_is_sig,
  input wire logic [63:0] res_index,
  input wire logic [7:0] res_mask,
  input wire logic irq_req,
  input wire logic [31:0] irq_dtype,
  input wire logic [15:0] irq_units,
  input wire logic [31:0] irq_tdata,
  input wire logic irq_tvalid,
  output logic irq_tready,
  input wire logic mm_valid,
  input wire logic mm_word_access,
  input wire logic [15:0] mm_addr,
  output logic mm_sel_ctrl,
  output logic mm_sel_cop,
  output logic mm_err
);

  typedef enum {R_HDR, R_DEC, R_FWD, R_DROP} scd_rx_e;
  typedef enum {T_IDLE, T_CMD, T_RESW, T_RES, T_IRQ} scd_tx_e;
  typedef enum {K_ACK, K_STATUS, K_IGNORE} scd_kind_e;

  scd_rx_e r_state_q, r_state_d;
  scd_tx_e t_state_q;
  scd_kind_e rep_kind_q, t_kind_q;
  logic [DW-1:0] hdr_q, rep_hdr_q, t_hdr_q;
  logic [CNT_W-1:0] rcnt_q, rcnt_d, hdr_words;
  logic rx_tready_q, rx_acc;
  logic eng_tvalid_q, eng_tvalid_d, eng_tlast_q, eng_sel_sig_q;
  logic [DW-1:0] eng_tdata_q;
  logic rep_pend_q, srst_q, tx_take, tx_free;
  logic [31:0] ignore_cnt_q;
  logic [31:0] hdr_type, hdr_len;
  logic is_reset, is_status, is_pow, is_sig, is_fwd;
  logic [DW-1:0] tx_tdata_q;
  logic tx_tvalid_q, tx_tlast_q;
  logic [2:0] tw_q;
  logic res_ready_q, res_sig_q, irq_tready_q, half_q;
  logic [63:0] res_index_q;
  logic [7:0] res_mask_q;
  logic [31:0] lo_q, irq_len;
  logic [15:0] units_q;
  logic mm_sel_ctrl_q, mm_sel_cop_q, mm_err_q;

  assign rx_acc = rx_tvalid && rx_tready_q;
  // Low half of a beat is the type, high half the byte length.
  assign hdr_type = hdr_q[31:0];
  assign hdr_len = hdr_q[63:32];
  // Packets always occupy whole 8-byte beats, so the next header is aligned.
  assign hdr_words = CNT_W'(({1'b0, hdr_len} + WORD_ROUND) >> WORD_SHIFT);
  assign is_reset = (hdr_type == TYPE_RESET) && (hdr_len == HDR_BYTES);
  assign is_status = (hdr_type == TYPE_STATUS) && (hdr_len == HDR_BYTES);
  assign is_pow = (hdr_type == TYPE_POW) && (hdr_len == LEN_POW) &&
                  CAP_MASK[CAP_POW_200_9];
  assign is_sig = (hdr_type == TYPE_SIG) && (hdr_len == LEN_SIG) &&
                  CAP_MASK[CAP_SIG];
  assign is_fwd = is_pow || is_sig;
  assign tx_free = !tx_tvalid_q || tx_tready;
  assign tx_take = (t_state_q == T_IDLE) && rep_pend_q && !srst_q;
  assign irq_len = HDR_BYTES + DTYPE_BYTES + ({16'h0, units_q} << UNIT_SHIFT);

  // Receive sequencing; the payload passes one beat at a time to the engines.
  always_comb begin
    r_state_d = r_state_q;
    rcnt_d = rcnt_q;
    eng_tvalid_d = eng_tvalid_q && !eng_tready;
    case (r_state_q)
      R_HDR: begin
        if (rx_acc) begin
          r_state_d = R_DEC;
        end
      end
      R_DEC: begin
        if (!rep_pend_q) begin
          rcnt_d = (hdr_words == '0) ? '0 : hdr_words - CNT_W'(1);
          if (is_fwd) begin
            r_state_d = R_FWD;
          end else if (rcnt_d != '0) begin
            r_state_d = R_DROP;
          end else begin
            r_state_d = R_HDR;
          end
        end
      end
      R_FWD: begin
        if (rx_acc) begin
          eng_tvalid_d = 1'b1;
          rcnt_d = rcnt_q - CNT_W'(1);
          if (rcnt_q == CNT_W'(1)) begin
            r_state_d = R_HDR;
          end
        end
      end
      R_DROP: begin
        if (rx_acc) begin
          rcnt_d = rcnt_q - CNT_W'(1);
          if (rcnt_q == CNT_W'(1)) begin
            r_state_d = R_HDR;
          end
        end
      end
      default: begin
        r_state_d = R_HDR;
      end
    endcase
    if (srst_q) begin
      eng_tvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_state_q <= R_HDR;
      rcnt_q <= '0;
      rx_tready_q <= 1'b0;
      hdr_q <= '0;
    end else begin
      r_state_q <= r_state_d;
      rcnt_q <= rcnt_d;
      rx_tready_q <= (r_state_d == R_HDR) || (r_state_d == R_DROP) ||
                     ((r_state_d == R_FWD) && !eng_tvalid_d);
      if (rx_acc && (r_state_q == R_HDR)) begin
        hdr_q <= rx_tdata;
      end
    end
  end

  // Engine feed: index beat first, then the body; the engine echoes the index.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_tvalid_q <= 1'b0;
      eng_tdata_q <= '0;
      eng_tlast_q <= 1'b0;
      eng_sel_sig_q <= 1'b0;
    end else begin
      eng_tvalid_q <= eng_tvalid_d;
      if (rx_acc && (r_state_q == R_FWD)) begin
        eng_tdata_q <= rx_tdata;
        eng_tlast_q <= (rcnt_q == CNT_W'(1));
      end
      if ((r_state_q == R_DEC) && !rep_pend_q) begin
        // The signature engine uses its own base point; none is sent here.
        eng_sel_sig_q <= is_sig;
      end
    end
  end

  // Decoded commands that need a reply post it here for the transmit side.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rep_pend_q <= 1'b0;
      rep_kind_q <= K_ACK;
      rep_hdr_q <= '0;
      srst_q <= 1'b0;
      ignore_cnt_q <= '0;
    end else begin
      srst_q <= 1'b0;
      if (tx_take) begin
        rep_pend_q <= 1'b0;
      end
      if (srst_q) begin
        ignore_cnt_q <= '0;
      end
      if ((r_state_q == R_DEC) && !rep_pend_q && !is_fwd) begin
        rep_pend_q <= 1'b1;
        rep_hdr_q <= hdr_q;
        srst_q <= is_reset;
        if (is_reset) begin
          rep_kind_q <= K_ACK;
        end else if (is_status) begin
          rep_kind_q <= K_STATUS;
        end else begin
          rep_kind_q <= K_IGNORE;
          ignore_cnt_q <= ignore_cnt_q + 32'd1;
        end
      end
    end
  end

  function automatic logic [DW-1:0] cmd_word(scd_kind_e kind, logic [2:0] idx,
                                             logic [DW-1:0] ign, logic [31:0] cnt);
    logic [CAP_W-1:0] st;
    st = {32'h0, cnt};
    cmd_word = '0;
    case (kind)
      K_ACK: cmd_word = {HDR_BYTES, RPL_RESET};
      K_IGNORE: cmd_word = (idx == 3'd0) ? {LEN_IGNORE, RPL_IGNORE} : ign;
      K_STATUS: begin
        case (idx)
          3'd0: cmd_word = {LEN_STATUS, RPL_STATUS};
          3'd1: cmd_word = {BUILD_DATE[31:0], VERSION};
          3'd2: cmd_word = {BUILD_HOST[31:0], BUILD_DATE[63:32]};
          3'd3: cmd_word = {CAP_MASK[31:0], BUILD_HOST[63:32]};
          3'd4: cmd_word = {st[31:0], CAP_MASK[63:32]};
          default: cmd_word = {32'h0, st[63:32]};
        endcase
      end
      default: cmd_word = '0;
    endcase
  endfunction

  function automatic logic [2:0] cmd_last(scd_kind_e kind);
    case (kind)
      K_STATUS: cmd_last = STATUS_LAST;
      K_IGNORE: cmd_last = IGNORE_LAST;
      default: cmd_last = 3'd0;
    endcase
  endfunction

  // Transmit side: command replies first, then engine results, then interrupts.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_state_q <= T_IDLE;
      t_kind_q <= K_ACK;
      t_hdr_q <= '0;
      tw_q <= '0;
      tx_tdata_q <= '0;
      tx_tvalid_q <= 1'b0;
      tx_tlast_q <= 1'b0;
      res_ready_q <= 1'b0;
      res_sig_q <= 1'b0;
      res_index_q <= '0;
      res_mask_q <= '0;
      irq_tready_q <= 1'b0;
      half_q <= 1'b0;
      lo_q <= '0;
      units_q <= '0;
    end else if (srst_q) begin
      t_state_q <= T_IDLE;
      tw_q <= '0;
      tx_tvalid_q <= 1'b0;
      tx_tlast_q <= 1'b0;
      res_ready_q <= 1'b0;
      irq_tready_q <= 1'b0;
      half_q <= 1'b0;
      units_q <= '0;
    end else begin
      if (tx_tvalid_q && tx_tready) begin
        tx_tvalid_q <= 1'b0;
      end
      case (t_state_q)
        T_IDLE: begin
          tw_q <= '0;
          if (tx_take) begin
            t_kind_q <= rep_kind_q;
            t_hdr_q <= rep_hdr_q;
            t_state_q <= T_CMD;
          end else if (res_valid) begin
            res_ready_q <= 1'b1;
            t_state_q <= T_RESW;
          end else if (irq_req && CAP_MASK[CAP_COPROC]) begin
            lo_q <= irq_dtype;
            units_q <= irq_units;
            half_q <= 1'b1;
            t_state_q <= T_IRQ;
          end
        end
        T_CMD: begin
          if (tx_free) begin
            tx_tvalid_q <= 1'b1;
            tx_tdata_q <= cmd_word(t_kind_q, tw_q, t_hdr_q, ignore_cnt_q);
            tx_tlast_q <= (tw_q == cmd_last(t_kind_q));
            tw_q <= tw_q + 3'd1;
            if (tw_q == cmd_last(t_kind_q)) begin
              t_state_q <= T_IDLE;
            end
          end
        end
        T_RESW: begin
          if (res_valid && res_ready_q) begin
            res_ready_q <= 1'b0;
            res_sig_q <= res_is_sig;
            res_index_q <= res_index;
            res_mask_q <= res_mask;
            t_state_q <= T_RES;
          end
        end
        T_RES: begin
          if (tx_free) begin
            tx_tvalid_q <= 1'b1;
            tx_tlast_q <= (tw_q == RESULT_LAST);
            tw_q <= tw_q + 3'd1;
            if (tw_q == 3'd0) begin
              tx_tdata_q <= {LEN_RESULT, res_sig_q ? RPL_SIG : RPL_POW};
            end else if (tw_q == 3'd1) begin
              tx_tdata_q <= res_index_q;
            end else begin
              tx_tdata_q <= {56'h0, res_mask_q};
              t_state_q <= T_IDLE;
            end
          end
        end
        T_IRQ: begin
          if (tw_q == 3'd0) begin
            if (tx_free) begin
              tx_tvalid_q <= 1'b1;
              tx_tdata_q <= {irq_len, RPL_IRQ};
              tx_tlast_q <= 1'b0;
              tw_q <= 3'd1;
            end
          end else if (irq_tready_q && irq_tvalid) begin
            irq_tready_q <= 1'b0;
            units_q <= units_q - 16'd1;
            half_q <= !half_q;
            if (half_q) begin
              tx_tvalid_q <= 1'b1;
              tx_tdata_q <= {irq_tdata, lo_q};
              tx_tlast_q <= (units_q == 16'd1);
            end else begin
              lo_q <= irq_tdata;
            end
          end else if (units_q == '0) begin
            if (!half_q) begin
              t_state_q <= T_IDLE;
            end else if (tx_free) begin
              tx_tvalid_q <= 1'b1;
              tx_tdata_q <= {32'h0, lo_q};
              tx_tlast_q <= 1'b1;
              half_q <= 1'b0;
              t_state_q <= T_IDLE;
            end
          end else begin
            // Fetch a unit only when the output beat will be free to take it.
            irq_tready_q <= !(tx_tvalid_q && !tx_tready);
          end
        end
        default: begin
          t_state_q <= T_IDLE;
        end
      endcase
    end
  end

  // Memory-mapped decode: full-word accesses only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mm_sel_ctrl_q <= 1'b0;
      mm_sel_cop_q <= 1'b0;
      mm_err_q <= 1'b0;
    end else begin
      mm_sel_ctrl_q <= mm_valid && mm_word_access && (mm_addr <= MM_CTRL_HI);
      mm_sel_cop_q <= mm_valid && mm_word_access && (mm_addr >= MM_COP_LO) &&
                      (mm_addr <= MM_COP_HI);
      mm_err_q <= mm_valid && (!mm_word_access || (mm_addr > MM_COP_HI));
    end
  end

  assign rx_tready = rx_tready_q;
  assign tx_tdata = tx_tdata_q;
  assign tx_tvalid = tx_tvalid_q;
  assign tx_tlast = tx_tlast_q;
  assign eng_tdata = eng_tdata_q;
  assign eng_tvalid = eng_tvalid_q;
  assign eng_tlast = eng_tlast_q;
  assign eng_sel_sig = eng_sel_sig_q;
  assign eng_soft_rst = srst_q;
  assign res_ready = res_ready_q;
  assign irq_tready = irq_tready_q;
  assign mm_sel_ctrl = mm_sel_ctrl_q;
  assign mm_sel_cop = mm_sel_cop_q;
  assign mm_err = mm_err_q;

endmodule

// file: dv/scd_chk.sv
// Port-level checker for the stream command dispatcher.
// Assumes it is bound into scd_top and sees only that module's ports.
`timescale 1ns/1ps
module scd_chk
  import scd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [DW-1:0] rx_tdata,
  input wire logic rx_tvalid,
  input wire logic rx_tready,
  input wire logic [DW-1:0] tx_tdata,
  input wire logic tx_tvalid,
  input wire logic tx_tready,
  input wire logic tx_tlast,
  input wire logic eng_soft_rst,
  input wire logic mm_valid,
  input wire logic mm_word_access,
  input wire logic [15:0] mm_addr,
  input wire logic mm_sel_ctrl,
  input wire logic mm_sel_cop,
  input wire logic mm_err
);
  logic first_q;
  wire logic [31:0] tx_len = tx_tdata[63:32];
  wire logic [31:0] tx_type = tx_tdata[31:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Marks the first beat of each reply, where the header stands.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b1;
    end else if (eng_soft_rst) begin
      first_q <= 1'b1;
    end else if (tx_tvalid && tx_tready) begin
      first_q <= tx_tlast;
    end
  end
  sequence s_rst_cmd;
    rx_tvalid && rx_tready && rx_tdata == {HDR_BYTES, TYPE_RESET};
  endsequence
  sequence s_rst_ack;
    tx_tvalid && first_q && tx_tlast && tx_tdata == {HDR_BYTES, RPL_RESET};
  endsequence
  a_soft_rst_pulse: assert property (s_rst_cmd |-> ##[1:8] eng_soft_rst)
    else $error("soft reset pulse missing");
  a_reset_ack_sent: assert property (s_rst_cmd |-> ##[1:60] s_rst_ack)
    else $error("reset acknowledge missing");
  a_status_len: assert property (tx_tvalid && first_q && tx_type == RPL_STATUS |->
    tx_len == LEN_STATUS)
    else $error("status reply length wrong");
  a_ignore_len: assert property (tx_tvalid && first_q && tx_type == RPL_IGNORE |->
    tx_len == LEN_IGNORE && !tx_tlast)
    else $error("ignore reply header wrong");
  a_result_len: assert property (tx_tvalid && first_q &&
    (tx_type == RPL_POW || tx_type == RPL_SIG) |-> tx_len == LEN_RESULT)
    else $error("result reply length wrong");
  a_tx_beat_hold: assert property (tx_tvalid && !tx_tready |=> tx_tvalid &&
    $stable(tx_tdata) && $stable(tx_tlast))
    else $error("reply beat changed before taken");
  a_mm_ctrl_sel: assert property (mm_valid && mm_word_access &&
    mm_addr <= MM_CTRL_HI |=> mm_sel_ctrl && !mm_sel_cop && !mm_err)
    else $error("control decode wrong");
  a_mm_cop_sel: assert property (mm_valid && mm_word_access &&
    mm_addr inside {[MM_COP_LO:MM_COP_HI]} |=> mm_sel_cop && !mm_sel_ctrl && !mm_err)
    else $error("coprocessor decode wrong");
  a_mm_bad_err: assert property (mm_valid &&
    (!mm_word_access || mm_addr > MM_COP_HI) |=> mm_err && !mm_sel_ctrl && !mm_sel_cop)
    else $error("bad access not flagged");
endmodule
bind scd_top scd_chk scd_chk_inst (.clk, .rst_n, .rx_tdata, .rx_tvalid, .rx_tready, .tx_tdata,
  .tx_tvalid, .tx_tready, .tx_tlast, .eng_soft_rst, .mm_valid, .mm_word_access, .mm_addr,
  .mm_sel_ctrl, .mm_sel_cop, .mm_err);

// file: dv/scd_eng_model.sv
// Slow engine and coprocessor stand-in on the dispatcher's far side.
// Assumes tb starts interrupt traffic with a one-cycle irq_go pulse.
`timescale 1ns/1ps
module scd_eng_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [63:0] eng_tdata,
  input wire logic eng_tvalid,
  output logic eng_tready,
  input wire logic eng_tlast,
  input wire logic eng_sel_sig,
  output logic res_valid,
  input wire logic res_ready,
  output logic res_is_sig,
  output logic [63:0] res_index,
  output logic [7:0] res_mask,
  input wire logic irq_go,
  output logic irq_req,
  output logic [31:0] irq_dtype,
  output logic [15:0] irq_units,
  output logic [31:0] irq_tdata,
  output logic irq_tvalid,
  input wire logic irq_tready
);
  logic first_q;
  logic [15:0] left_q;
  // Takes a beat only every other cycle, as a busy engine would.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) eng_tready <= 1'b0;
    else eng_tready <= ~eng_tready;
  end
  // Released result index and mask are inverted so stale values cannot match.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b1;
      res_valid <= 1'b0;
      res_is_sig <= 1'b0;
      res_index <= 64'h0;
      res_mask <= 8'h0;
    end else if (eng_tvalid && eng_tready) begin
      first_q <= eng_tlast;
      if (first_q) res_index <= eng_tdata;
      if (eng_tlast) begin
        res_valid <= 1'b1;
        res_is_sig <= eng_sel_sig;
        res_mask <= eng_sel_sig ? 8'h00 : 8'h03;
      end
    end else if (res_valid && res_ready) begin
      res_valid <= 1'b0;
      res_index <= ~res_index;
      res_mask <= ~res_mask;
    end
  end
  assign irq_dtype = 32'h00000007;
  assign irq_units = 16'h0003;
  assign irq_tvalid = left_q != 16'h0;
  assign irq_req = irq_tvalid;
  assign irq_tdata = 32'hd0d00003 - {16'h0, left_q};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) left_q <= 16'h0;
    else if (irq_go) left_q <= irq_units;
    else if (irq_tvalid && irq_tready) left_q <= left_q - 16'h1;
  end
endmodule

// file: dv/tb.sv
// Self-checking bench: host packets, engine results, interrupt and map decode.
// Assumes scd_eng_model on the engine side and scd_chk bound into scd_top.
`timescale 1ns/1ps
module tb;
  import scd_pkg::*;
  localparam logic [63:0] DATE = 64'h1112131415161718;
  localparam logic [63:0] HOST = 64'h2122232425262728;
  localparam logic [31:0] VER = 32'h00010203;
  localparam logic [23:0] MMT [6] = '{24'h100004, 24'h10fff4, 24'h110002, 24'h14fff2,
    24'h150001, 24'h001001};
  logic clk = 1'b0, rst_n = 1'b0, rx_tvalid = 1'b0, tx_tready = 1'b0;
  logic stall = 1'b0, mm_valid = 1'b0, mm_word_access = 1'b0, irq_go = 1'b0;
  logic [63:0] rx_tdata = 64'h0;
  logic [15:0] mm_addr = 16'h0;
  wire rx_tready, tx_tvalid, tx_tlast, eng_tvalid, eng_tready, eng_tlast, eng_sel_sig;
  wire eng_soft_rst, res_valid, res_ready, res_is_sig, irq_req, irq_tvalid, irq_tready;
  wire mm_sel_ctrl, mm_sel_cop, mm_err;
  wire [63:0] tx_tdata, eng_tdata, res_index;
  wire [31:0] irq_dtype, irq_tdata;
  wire [15:0] irq_units;
  wire [7:0] res_mask;
  int fail_count = 0;
  int comparisons = 0;
  always #10 clk = ~clk;
  always @(posedge clk) tx_tready <= #1 (stall ? ~tx_tready : 1'b1);
  scd_top #(.VERSION(VER), .BUILD_DATE(DATE), .BUILD_HOST(HOST), .CAP_MASK(64'hd)) scd_top_inst (
    .clk, .rst_n, .rx_tdata, .rx_tvalid, .rx_tready, .tx_tdata, .tx_tvalid, .tx_tready,
    .tx_tlast, .eng_tdata, .eng_tvalid, .eng_tready, .eng_tlast, .eng_sel_sig, .eng_soft_rst,
    .res_valid, .res_ready, .res_is_sig, .res_index, .res_mask, .irq_req, .irq_dtype,
    .irq_units, .irq_tdata, .irq_tvalid, .irq_tready, .mm_valid, .mm_word_access, .mm_addr,
    .mm_sel_ctrl, .mm_sel_cop, .mm_err);
  scd_eng_model scd_eng_model_inst (.clk, .rst_n, .eng_tdata, .eng_tvalid, .eng_tready,
    .eng_tlast, .eng_sel_sig, .res_valid, .res_ready, .res_is_sig, .res_index, .res_mask,
    .irq_go, .irq_req, .irq_dtype, .irq_units, .irq_tdata, .irq_tvalid, .irq_tready);
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bound(input int n, input string what);
    if (n >= 3000) begin
      fail_count++;
      $display("ERROR %s expected handshake seen timeout", what);
      tally_and_finish();
    end
  endtask
  task automatic send(input logic [63:0] beat);
    int n;
    n = 0;
    rx_tdata = beat;
    rx_tvalid = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rx_tready !== 1'b1 && n < 3000);
    bound(n, "rx_tready");
    #1;
  endtask
  task automatic pkt(input logic [63:0] hdr, input int nb, input logic [63:0] idx);
    send(hdr);
    for (int i = 1; i <= nb; i++) send(i == 1 ? idx : {i, ~i});
  endtask
  task automatic recv(input logic [63:0] exp, input logic last);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((tx_tvalid && tx_tready) !== 1'b1 && n < 3000);
    bound(n, "tx_tvalid");
    chk("tx_tdata", exp, tx_tdata);
    chk("tx_tlast", {63'h0, last}, {63'h0, tx_tlast});
    // Step off the edge so that whatever follows is driven away from it.
    #1;
  endtask
  task automatic st_exp(input logic [31:0] ign);
    logic [319:0] st;
    st = {64'h0, ign, 64'hd, HOST, DATE, VER};
    recv({LEN_STATUS, RPL_STATUS}, 1'b0);
    for (int i = 0; i < 5; i++) recv(st[64*i+:64], i == 4);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    fork
      begin
        send({HDR_BYTES, TYPE_RESET});
        rx_tvalid = 1'b0;
      end
      recv({HDR_BYTES, RPL_RESET}, 1'b1);
    join
    $display("test soft reset done");
    stall = 1'b1;
    fork
      begin
        send({HDR_BYTES, TYPE_STATUS});
        rx_tvalid = 1'b0;
      end
      st_exp(32'h0);
    join
    stall = 1'b0;
    $display("test status done");
    fork
      begin
        pkt({32'h18, 32'h00000042}, 2, 64'h0);
        pkt({32'h14, TYPE_SIG}, 2, 64'h0);
        send({HDR_BYTES, TYPE_STATUS});
        rx_tvalid = 1'b0;
      end
      begin
        recv({LEN_IGNORE, RPL_IGNORE}, 1'b0);
        recv({32'h18, 32'h00000042}, 1'b1);
        recv({LEN_IGNORE, RPL_IGNORE}, 1'b0);
        recv({32'h14, TYPE_SIG}, 1'b1);
        st_exp(32'h2);
      end
    join
    $display("test ignore done");
    for (int k = 0; k < 2; k++) begin
      fork
        begin
          pkt(k ? {LEN_POW, TYPE_POW} : {LEN_SIG, TYPE_SIG}, k ? 187 : 21,
              64'h0123456789abcd00 + k);
          rx_tvalid = 1'b0;
        end
        begin
          recv({LEN_RESULT, k ? RPL_POW : RPL_SIG}, 1'b0);
          recv(64'h0123456789abcd00 + k, 1'b0);
          recv({56'h0, k ? 8'h03 : 8'h00}, 1'b1);
        end
      join
    end
    $display("test verify done");
    fork
      begin
        irq_go = 1'b1;
        @(posedge clk);
        #1 irq_go = 1'b0;
      end
      begin
        recv({32'h18, RPL_IRQ}, 1'b0);
        recv(64'hd0d0000000000007, 1'b0);
        recv(64'hd0d00002d0d00001, 1'b1);
      end
    join
    $display("test interrupt done");
    mm_valid = 1'b1;
    for (int i = 0; i < 6; i++) begin
      mm_word_access = MMT[i][20];
      mm_addr = MMT[i][19:4];
      @(posedge clk);
      #1;
      chk("mm_sel", {61'h0, MMT[i][2:0]},
          {61'h0, mm_sel_ctrl, mm_sel_cop, mm_err});
    end
    mm_valid = 1'b0;
    $display("test map decode done");
    tally_and_finish();
  end
endmodule
